// ===== src/rlx_pkg.sv
`default_nettype none
package rlx_pkg;
	// APB word offsets (byte addresses)
	localparam logic [7:0] RLX_OFF_FEATURE = 8'h04;
	localparam logic [7:0] RLX_OFF_COUNT = 8'h08;
	localparam logic [7:0] RLX_OFF_LOGSEL = 8'h0C;
	localparam logic [7:0] RLX_OFF_SECOFF = 8'h10;
	localparam logic [7:0] RLX_OFF_UPPER = 8'h14;
	localparam logic [7:0] RLX_OFF_DRVHEAD = 8'h18;
	localparam logic [7:0] RLX_OFF_OPCODE = 8'h1C;
	localparam logic [7:0] RLX_OFF_CTRL = 8'h20;
	localparam logic [7:0] RLX_OFF_FAULT = 8'h24;
	localparam logic [7:0] RLX_OFF_SUPPORT = 8'h28;
	localparam logic [7:0] RLX_OFF_XFER = 8'h2C;
	localparam logic [7:0] RLX_OFF_LOGSIZE = 8'h30;

	localparam logic [7:0] RLX_CMD_READ_LOG_EXT = 8'h2F;

	// Log addresses
	localparam logic [7:0] RLX_LOG_DIR = 8'h00;
	localparam logic [7:0] RLX_LOG_RSV1 = 8'h01;
	localparam logic [7:0] RLX_LOG_SMART_ERR = 8'h02;
	localparam logic [7:0] RLX_LOG_EXT_ERR = 8'h03;
	localparam logic [7:0] RLX_LOG_RSV4 = 8'h04;
	localparam logic [7:0] RLX_LOG_RSV5 = 8'h05;
	localparam logic [7:0] RLX_LOG_SELFTEST = 8'h06;
	localparam logic [7:0] RLX_LOG_EXT_ST = 8'h07;
	localparam logic [7:0] RLX_LOG_HOST_LO = 8'h80;
	localparam logic [7:0] RLX_LOG_HOST_HI = 8'h9F;
	localparam logic [7:0] RLX_LOG_DEV_LO = 8'hA0;
	localparam logic [7:0] RLX_LOG_DEV_HI = 8'hBF;
	localparam logic [15:0] RLX_HOST_LOG_SECTORS = 16'h0010;

	// Status bits
	localparam int RLX_ST_ERR = 0;
	localparam int RLX_ST_DRQ = 3;
	localparam int RLX_ST_DF = 5;
	localparam int RLX_ST_DEVICE_READY_FLAG = 6;
	localparam int RLX_ST_BSY = 7;
	// Error bits
	localparam int RLX_ER_COMMAND_ABORTED_FLAG = 2;
	localparam int RLX_ER_ID_NOT_FOUND_FLAG = 4;
	localparam int RLX_ER_UNC = 6;
	// Field positions
	localparam int RLX_DH_DEV = 4;
	localparam int RLX_CTRL_HOB = 0;
	localparam int RLX_CTRL_HOST_WR = 1;
	localparam int RLX_SUP_GPL = 0;
	localparam int RLX_SUP_SMART_ERR = 1;
	localparam int RLX_SUP_SMART_ST = 2;
	localparam int RLX_SUP_SMART = 3;
	localparam int RLX_SUP_DEV_VS = 4;
	localparam int RLX_SUP_UNC = 5;
	localparam int RLX_SUP_ID_NOT_FOUND_FLAG = 6;
	localparam int RLX_SUP_FAULT = 7;

	localparam logic [7:0] RLX_STATUS_RESET = 8'h40;
	localparam logic [7:0] RLX_ZERO8 = 8'h00;
	localparam logic [15:0] RLX_ZERO16 = 16'h0000;
	localparam logic [15:0] RLX_ONE16 = 16'h0001;
	localparam logic [15:0] RLX_FIXED_LOG_SECTORS = 16'h0001;
	localparam logic [7:0] RLX_ERR_ABORT = 8'h04;
	localparam logic [7:0] RLX_STATUS_ABORT = 8'h41;
	localparam logic [7:0] RLX_STATUS_BUSY = 8'h88;

	typedef struct packed {
		logic [7:0] prev;
		logic [7:0] cur;
	} rlx_pair_type;

	typedef struct packed {
		logic [15:0] count;
		logic [7:0] log_addr;
		logic [15:0] offset;
		logic zero_fill;
	} rlx_xfer_type;
endpackage
`default_nettype wire

// ===== src/rlx_read_log_ext.sv
// Notes on behaviour
// - Sector count is previous byte as 15:8, current byte as 7:0.
// - Log address is current byte of log_select; previous byte is reserved.
// - Sector offset is previous:current bytes of sector_offset.
// - Transfer begins at the offset sector regardless of requested count.
// - Logs 00h, 03h, 07h read-only; 01h, 04h-05h, 08h-7Fh, C0h-FFh reserved.
// - Logs 80h-9Fh host read/write; A0h-BFh device vendor access.
// - Log address 02h or 06h aborts the command.
// - Never-written host vendor log reads back as zeros.
// - A log exists only when its feature set is implemented.
// - Device vendor logs exist only if the vendor uses them.
// - Abort on unsupported command, feature set or invalid parameter values.
// - Success: busy 0, ready 1, fault 0, data request 0, error 0; the code takes fault from support bit 7, error from err_bits.
// - Drive select bit mirrors the selected device in all outputs; here it only reads back from drive_head_select_reg.
// - High-byte select chooses previous byte on parameter readback.
// - Extended error log holds the 28-bit error entries too.
// - Extended self-test log holds 28-bit and 48-bit entries.
// - Data moves device to host by PIO data-in.
// - One interrupt per data-request block transferred.
// - Abort when count is zero or exceeds the directory log size; the code aborts when offset plus count exceeds log_size.
// - Uncorrectable error bit set for any uncorrectable requested sector.
`default_nettype none
module rlx_read_log_ext
	import rlx_pkg::*;
#(
	parameter logic [15:0] DEV_VS_SECTORS = 16'h0001
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic block_done,
	output logic xfer_start,
	output var rlx_xfer_type xfer_info,
	output logic block_irq
);

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	logic setup;
	logic wr;
	logic rd;
	logic known;
	assign setup = psel && !penable;
	assign wr = setup && pwrite;
	assign rd = setup && !pwrite;
	always_comb begin
		unique case (paddr)
			RLX_OFF_FEATURE, RLX_OFF_COUNT, RLX_OFF_LOGSEL, RLX_OFF_SECOFF,
			RLX_OFF_UPPER, RLX_OFF_DRVHEAD, RLX_OFF_OPCODE, RLX_OFF_CTRL,
			RLX_OFF_FAULT, RLX_OFF_SUPPORT, RLX_OFF_XFER,
			RLX_OFF_LOGSIZE: known = 1'b1;
			default: known = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// Parameter pairs: write shifts current into previous
	// ----------------------------------------------------------------
	rlx_pair_type feature_parameter_reg;
	rlx_pair_type transfer_count_reg;
	rlx_pair_type log_select_reg;
	rlx_pair_type sector_offset_reg;
	rlx_pair_type upper_address_reg;
	logic [7:0] drive_head_select_reg;
	logic [7:0] ctrl_reg;
	logic [7:0] support_reg;

	function automatic rlx_pair_type push(rlx_pair_type p, logic [7:0] d);
		rlx_pair_type r;
		r.prev = p.cur;
		r.cur = d;
		return r;
	endfunction

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			feature_parameter_reg <= '0;
			transfer_count_reg <= '0;
			log_select_reg <= '0;
			sector_offset_reg <= '0;
			upper_address_reg <= '0;
			drive_head_select_reg <= RLX_ZERO8;
			ctrl_reg <= RLX_ZERO8;
			support_reg <= RLX_ZERO8;
		end else if (wr) begin
			unique case (paddr)
				RLX_OFF_FEATURE: feature_parameter_reg <=
					push(feature_parameter_reg, pwdata[7:0]);
				RLX_OFF_COUNT: transfer_count_reg <=
					push(transfer_count_reg, pwdata[7:0]);
				RLX_OFF_LOGSEL: log_select_reg <=
					push(log_select_reg, pwdata[7:0]);
				RLX_OFF_SECOFF: sector_offset_reg <=
					push(sector_offset_reg, pwdata[7:0]);
				RLX_OFF_UPPER: upper_address_reg <=
					push(upper_address_reg, pwdata[7:0]);
				RLX_OFF_DRVHEAD: drive_head_select_reg <= pwdata[7:0];
				RLX_OFF_CTRL: ctrl_reg <= pwdata[7:0];
				RLX_OFF_SUPPORT: support_reg <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Parameter decode
	// ----------------------------------------------------------------
	logic [15:0] count;
	logic [15:0] offset;
	logic [7:0] log_addr;
	logic [15:0] log_size;
	logic log_ok;
	logic host_log;
	logic dev_log;
	assign count = {transfer_count_reg.prev, transfer_count_reg.cur};
	assign log_addr = log_select_reg.cur;
	assign offset = {sector_offset_reg.prev, sector_offset_reg.cur};
	assign host_log = log_addr >= RLX_LOG_HOST_LO &&
		log_addr <= RLX_LOG_HOST_HI;
	assign dev_log = log_addr >= RLX_LOG_DEV_LO &&
		log_addr <= RLX_LOG_DEV_HI;

	// Reserved addresses fall to default, legacy-only 02h and 06h to their own item; both abort
	always_comb begin
		log_ok = 1'b0;
		log_size = RLX_ZERO16;
		if (host_log) begin
			log_ok = support_reg[RLX_SUP_SMART];
			log_size = RLX_HOST_LOG_SECTORS;
		end else if (dev_log) begin
			log_ok = support_reg[RLX_SUP_DEV_VS];
			log_size = DEV_VS_SECTORS;
		end else begin
			unique case (log_addr)
				RLX_LOG_DIR: begin
					log_ok = support_reg[RLX_SUP_GPL];
					log_size = RLX_FIXED_LOG_SECTORS;
				end
				// Ext logs carry 28- and 48-bit entries
				RLX_LOG_EXT_ERR: begin
					log_ok = support_reg[RLX_SUP_SMART_ERR];
					log_size = RLX_FIXED_LOG_SECTORS;
				end
				RLX_LOG_EXT_ST: begin
					log_ok = support_reg[RLX_SUP_SMART_ST];
					log_size = RLX_FIXED_LOG_SECTORS;
				end
				RLX_LOG_SMART_ERR, RLX_LOG_SELFTEST: log_ok = 1'b0;
				default: log_ok = 1'b0;
			endcase
		end
	end

	logic [16:0] last_sector;
	logic abort;
	assign last_sector = {1'b0, offset} + {1'b0, count};
	assign abort = !support_reg[RLX_SUP_GPL] || !log_ok ||
		feature_parameter_reg != '0 || upper_address_reg != '0 ||
		count == RLX_ZERO16 || last_sector > {1'b0, log_size};

	// ----------------------------------------------------------------
	// Command execution
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		RLX_IDLE = 3'b001,
		RLX_XFER = 3'b010,
		RLX_DONE = 3'b100
	} rlx_state_type;
	rlx_state_type state_reg;
	logic [7:0] completion_state_reg;
	logic [7:0] fault_cause_reg;
	logic [15:0] remain_reg;
	logic cmd_go;
	assign cmd_go = wr && paddr == RLX_OFF_OPCODE &&
		pwdata[7:0] == RLX_CMD_READ_LOG_EXT;
	logic bad_cmd;
	assign bad_cmd = wr && paddr == RLX_OFF_OPCODE &&
		pwdata[7:0] != RLX_CMD_READ_LOG_EXT;

	logic [7:0] err_bits;
	assign err_bits = {1'b0, support_reg[RLX_SUP_UNC], 1'b0,
		support_reg[RLX_SUP_ID_NOT_FOUND_FLAG], 3'b000, 1'b0};

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			state_reg <= RLX_IDLE;
			completion_state_reg <= RLX_STATUS_RESET;
			fault_cause_reg <= RLX_ZERO8;
			remain_reg <= RLX_ZERO16;
			xfer_start <= 1'b0;
			xfer_info <= '0;
			block_irq <= 1'b0;
		end else begin
			xfer_start <= 1'b0;
			block_irq <= 1'b0;
			unique case (state_reg)
				RLX_IDLE: begin
					if (bad_cmd) begin
						fault_cause_reg <= RLX_ERR_ABORT;
						completion_state_reg <= RLX_STATUS_ABORT;
					end else if (cmd_go && abort) begin
						fault_cause_reg <= RLX_ERR_ABORT;
						completion_state_reg <= RLX_STATUS_ABORT;
					end else if (cmd_go) begin
						fault_cause_reg <= RLX_ZERO8;
						completion_state_reg <= RLX_STATUS_BUSY;
						remain_reg <= count;
						xfer_start <= 1'b1;
						xfer_info.count <= count;
						xfer_info.log_addr <= log_addr;
						xfer_info.offset <= offset;
						xfer_info.zero_fill <= host_log &&
							!ctrl_reg[RLX_CTRL_HOST_WR];
						state_reg <= RLX_XFER;
					end
				end
				RLX_XFER: begin
					if (block_done) begin
						block_irq <= 1'b1;
						remain_reg <= remain_reg - RLX_ONE16;
						if (remain_reg == RLX_ONE16)
							state_reg <= RLX_DONE;
					end
				end
				RLX_DONE: begin
					state_reg <= RLX_IDLE;
					fault_cause_reg <= err_bits;
					// Ready set, busy and request clear either way
					completion_state_reg <= {1'b0, 1'b1,
						support_reg[RLX_SUP_FAULT], 1'b0, 1'b0, 2'b00,
						err_bits != RLX_ZERO8};
				end
				default: state_reg <= RLX_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	logic high_byte_readback_select;
	assign high_byte_readback_select = ctrl_reg[RLX_CTRL_HOB];
	function automatic logic [7:0] pick(rlx_pair_type p, logic h);
		return h ? p.prev : p.cur;
	endfunction

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			pslverr <= setup && !known;
			prdata <= '0;
			if (rd) begin
				unique case (paddr)
					RLX_OFF_COUNT:
						prdata[7:0] <= pick(transfer_count_reg, high_byte_readback_select);
					RLX_OFF_LOGSEL:
						prdata[7:0] <= pick(log_select_reg, high_byte_readback_select);
					RLX_OFF_SECOFF:
						prdata[7:0] <= pick(sector_offset_reg, high_byte_readback_select);
					RLX_OFF_UPPER:
						prdata[7:0] <= pick(upper_address_reg, high_byte_readback_select);
					RLX_OFF_DRVHEAD:
						prdata[7:0] <= drive_head_select_reg;
					RLX_OFF_OPCODE: prdata[7:0] <= completion_state_reg;
					RLX_OFF_CTRL: prdata[7:0] <= ctrl_reg;
					RLX_OFF_FAULT: prdata[7:0] <= fault_cause_reg;
					RLX_OFF_SUPPORT: prdata[7:0] <= support_reg;
					RLX_OFF_XFER: prdata[15:0] <= remain_reg;
					RLX_OFF_LOGSIZE: prdata[15:0] <= log_size;
					default: ;
				endcase
			end
		end
	end

endmodule
`default_nettype wire

// ===== dv/rlx_assertions.sv
`default_nettype none
module rlx_assertions
	import rlx_pkg::*;
(
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic block_done,
	input wire logic xfer_start,
	input wire rlx_xfer_type xfer_info,
	input wire logic block_irq
);
	timeunit 1ns;
	timeprecision 1ns;
	logic op_wr;
	assign op_wr = psel && !penable && pwrite && paddr == RLX_OFF_OPCODE
		&& pwdata[7:0] == RLX_CMD_READ_LOG_EXT;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!nrst);
	property p_answer;
		psel && !penable |=> pready;
	endproperty
	a_answer: assert property (p_answer) else $error("late answer");
	property p_pulse;
		pready |=> !pready;
	endproperty
	a_pulse: assert property (p_pulse) else $error("pready held");
	property p_start;
		xfer_start |-> $past(op_wr, 1) || $past(op_wr, 2);
	endproperty
	a_start: assert property (p_start) else $error("start uncaused");
	property p_smart;
		xfer_start |-> !(xfer_info.log_addr inside {8'h02, 8'h06});
	endproperty
	a_smart: assert property (p_smart) else $error("log not aborted");
	property p_rsv;
		xfer_start |-> !(xfer_info.log_addr inside {8'h01, 8'h04, 8'h05,
			[8'h08:8'h7F], [8'hC0:8'hFF]});
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved log read");
	property p_count;
		xfer_start |-> xfer_info.count != 16'h0000;
	endproperty
	a_count: assert property (p_count) else $error("zero count ran");
	property p_irq;
		block_irq |-> $past(block_done);
	endproperty
	a_irq: assert property (p_irq) else $error("stray irq");
	property p_irq_once;
		block_done |=> block_irq ##1 !block_irq;
	endproperty
	a_irq_once: assert property (p_irq_once) else $error("irq count");
endmodule
`default_nettype wire

// ===== dv/rlx_pio_model.sv
`default_nettype none
module rlx_pio_model
	import rlx_pkg::*;
(
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic xfer_start,
	input wire rlx_xfer_type xfer_info,
	output logic block_done
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] left_reg;
	logic [2:0] wait_reg;
	logic slow_reg;
	// Quick and slow blocks alternate
	always_ff @(posedge core_clk) begin
		block_done <= 1'b0;
		if (!nrst) begin
			left_reg <= 16'h0000;
			wait_reg <= 3'h0;
			slow_reg <= 1'b0;
		end else if (xfer_start) begin
			left_reg <= xfer_info.count;
			wait_reg <= 3'h1;
		end else if (left_reg != 16'h0000) begin
			if (wait_reg == 3'h0) begin
				block_done <= 1'b1;
				left_reg <= left_reg - 16'h0001;
				slow_reg <= ~slow_reg;
				wait_reg <= slow_reg ? 3'h1 : 3'h6;
			end else
				wait_reg <= wait_reg - 3'h1;
		end
	end
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
`default_nettype none
module tb_top
	import rlx_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, er;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, rd, prdata;
	logic pready, pslverr, block_done, xfer_start, block_irq;
	rlx_xfer_type xfer_info, got;
	int n_mismatch = 0, comparisons = 0, n_irq = 0, n0;
	logic [7:0] bad [6] = '{8'h02, 8'h06, 8'h01, 8'hC0, 8'h03, 8'hA0};
	always #25 core_clk = ~core_clk;
	rlx_read_log_ext dut_u (.core_clk, .nrst, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .block_done,
		.xfer_start, .xfer_info, .block_irq);
	rlx_pio_model pio_u (.core_clk, .nrst, .xfer_start, .xfer_info,
		.block_done);
	always @(posedge core_clk) begin
		if (block_irq === 1'b1)
			n_irq++;
		if (xfer_start === 1'b1)
			got = xfer_info;
	end
	// ------
	// Tasks
	// ------
	task automatic print_verdict;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [40:0] g, input logic [40:0] e);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int t;
		t = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1 && ++t < 50);
		if (pready !== 1'b1)
			n_mismatch++;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic cmd(input logic [7:0] lg, input logic [15:0] cnt,
		input logic [15:0] off, input logic [7:0] op, input logic [7:0] st,
		input logic [7:0] ev, input int nb);
		int t;
		apb(1, RLX_OFF_COUNT, cnt[15:8]);
		apb(1, RLX_OFF_COUNT, cnt[7:0]);
		apb(1, RLX_OFF_SECOFF, off[15:8]);
		apb(1, RLX_OFF_SECOFF, off[7:0]);
		apb(1, RLX_OFF_LOGSEL, lg);
		n0 = n_irq;
		apb(1, RLX_OFF_OPCODE, op);
		t = 0;
		do begin
			apb(0, RLX_OFF_OPCODE, 8'h00);
			t++;
		end while (rd[7] !== 1'b0 && t < 100);
		chk(rd, st);
		apb(0, RLX_OFF_FAULT, 8'h00);
		chk(rd, ev);
		chk(41'(n_irq - n0), 41'(nb));
		$display("command %h on log %h done", op, lg);
	endtask
	initial begin
		#1000000;
		n_mismatch++;
		print_verdict();
	end
	initial begin
		repeat (12) @(posedge core_clk);
		nrst <= 1'b1;
		@(posedge core_clk);
		apb(0, RLX_OFF_OPCODE, 8'h00);
		chk(rd, RLX_STATUS_RESET);
		apb(0, 8'h3C, 8'h00);
		chk({er, rd}, {1'b1, 32'h0});
		apb(1, RLX_OFF_COUNT, 8'hA5);
		apb(1, RLX_OFF_COUNT, 8'h3C);
		apb(1, RLX_OFF_CTRL, 8'h01);
		apb(0, RLX_OFF_COUNT, 8'h00);
		chk(rd, 8'hA5);
		apb(1, RLX_OFF_CTRL, 8'h00);
		apb(0, RLX_OFF_COUNT, 8'h00);
		chk(rd, 8'h3C);
		$display("readback test done");
		apb(1, RLX_OFF_SUPPORT, 8'h09);
		apb(1, RLX_OFF_DRVHEAD, 8'h10);
		cmd(RLX_LOG_HOST_LO, 2, 1, 8'h2F, 8'h40, 8'h00, 2);
		apb(0, RLX_OFF_XFER, 8'h00);
		chk(rd, 32'h0);
		apb(0, RLX_OFF_LOGSIZE, 8'h00);
		chk(rd, {16'h0, RLX_HOST_LOG_SECTORS});
		chk(got, {16'h0002, RLX_LOG_HOST_LO, 16'h0001, 1'b1});
		apb(0, RLX_OFF_DRVHEAD, 8'h00);
		chk(rd, 8'h10);
		foreach (bad[i])
			cmd(bad[i], 1, 0, 8'h2F, 8'h41, 8'h04, 0);
		cmd(RLX_LOG_HOST_LO, 0, 0, 8'h2F, 8'h41, 8'h04, 0);
		cmd(RLX_LOG_HOST_LO, 16, 1, 8'h2F, 8'h41, 8'h04, 0);
		cmd(RLX_LOG_HOST_HI, 16, 0, 8'h2F, 8'h40, 8'h00, 16);
		cmd(RLX_LOG_HOST_LO, 1, 0, 8'h30, 8'h41, 8'h04, 0);
		cmd(RLX_LOG_DIR, 1, 0, 8'h2F, 8'h40, 8'h00, 1);
		apb(1, RLX_OFF_FEATURE, 8'h01);
		cmd(RLX_LOG_HOST_LO, 1, 0, 8'h2F, 8'h41, 8'h04, 0);
		apb(1, RLX_OFF_FEATURE, 8'h00);
		apb(1, RLX_OFF_FEATURE, 8'h00);
		apb(1, RLX_OFF_SUPPORT, 8'h29);
		cmd(RLX_LOG_HOST_LO, 1, 0, 8'h2F, 8'h41, 8'h40, 1);
		print_verdict();
	end
endmodule
bind rlx_read_log_ext rlx_assertions chk_u (.core_clk, .nrst, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.block_done, .xfer_start, .xfer_info, .block_irq);
`default_nettype wire
